/* common/cbt_regs.svh */
// register offsets, field positions and constants of the block transfer channel
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH
`define CBT_A_OUT5 8'h00
`define CBT_A_OUT6 8'h04
`define CBT_A_STAT5 8'h08
`define CBT_A_STAT6 8'h0c
`define CBT_Z16 16'h0000
`define CBT_Z32 32'h0000_0000
`define CBT_CONN_CODE 4'hc
`define CBT_S_SA 0
`define CBT_S_TA 1
`define CBT_S_FN 2
`define CBT_S_CLR 3
`define CBT_S_CC 4
`define CBT_S_TB 5
`define CBT_S_CUR 6
`define CBT_F_CODED 15
`define CBT_F_WRITE 14
`define CBT_F_DISREQ 11
`define CBT_F_HALT 10
`define CBT_F_BACK 9
`define CBT_CMP_BIT 15
`define CBT_CCONN_BIT 13
`define CBT_PAGE_END 11'h7ff
`define CBT_PAGE_TOP 11'h000
`endif

/* common/cbt_pkg.sv */
// types shared by the block transfer channel
package cbt_pkg;
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_RXW   = 7'h02,
      ST_UNIT  = 7'h04,
      ST_LOOK  = 7'h08,
      ST_STORE = 7'h10,
      ST_FETCH = 7'h20,
      ST_SEND  = 7'h40
   } cbt_state_type;
endpackage

/* core/cbt_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cbt_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;
   if (W < 1) begin : g_chk
      $error("cbt_sync width must be at least one");
   end
   // first stage feeds only the second stage
   always_comb begin
      meta_d = d;
      q_d = meta_q;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else if (ce) begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule

/* core/cbt_top.sv */
// block transfer channel: host command path, table conversion and memory addressing
`timescale 1ns/1ps
`include "cbt_regs.svh"
module cbt_top #(
   parameter int AW = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mem_req,
   output logic mem_we,
   output logic [14:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_perr,
   input wire logic per_rx_valid,
   input wire logic [11:0] per_rx_byte,
   input wire logic per_eor,
   input wire logic per_rx_perr,
   input wire logic per_wr_perr,
   input wire logic per_tx_ack,
   input wire logic [11:0] per_status,
   output logic per_tx_valid,
   output logic [11:0] per_tx_byte,
   output logic per_code_stb,
   output logic per_code_conn,
   output logic [11:0] per_code,
   output cbt_pkg::cbt_state_type eng_state
);
   import cbt_pkg::*;

   if (AW < 8) begin : g_chk
      $error("cbt_top address width must be at least eight");
   end

   // ******************************************************
   // pin synchronisers
   // ******************************************************
   logic [4:0] ctl_s;
   logic [23:0] dat_s;
   logic [4:0] ctl_p_q;
   cbt_sync #(.W(5)) u_sync_ctl (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .d({per_rx_valid, per_eor, per_rx_perr, per_wr_perr, per_tx_ack}),
      .q(ctl_s)
   );
   cbt_sync #(.W(24)) u_sync_dat (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .d({per_rx_byte, per_status}),
      .q(dat_s)
   );
   logic rx_new, eor_new, txack_new;
   assign rx_new = ctl_s[4] & ~ctl_p_q[4];
   assign eor_new = ctl_s[3] & ~ctl_p_q[3];
   assign txack_new = ctl_s[0] & ~ctl_p_q[0];

   // ******************************************************
   // apb slave and host word registers
   // ******************************************************
   logic [15:0] out5_q, out5_d, out6_q, out6_d;
   logic pready_d, pslverr_d;
   logic [31:0] prdata_d;
   logic [6:0] stb;
   logic take, conn, wr6;
   logic [15:0] stat5;
   logic sbu_perr_q, rd_perr_q;
   logic [10:0] low_q;
   logic [3:0] page_q;
   logic [1:0] ucnt_q, bcnt_q;
   assign conn = out6_q[3:0] == `CBT_CONN_CODE;
   assign take = psel & penable & pready;
   assign wr6 = take & pwrite & (paddr[7:0] == `CBT_A_OUT6);
   // status word 5: error flags and either current address or counters
   assign stat5 = {3'h0, sbu_perr_q, rd_perr_q,
      out6_q[15-`CBT_S_CUR] ? low_q : {4'h0, 2'h0, ucnt_q, 1'b0, bcnt_q}};
   // strobe bits act on rising edge, only with the connect code present
   always_comb begin
      stb = '0;
      if (wr6 && pwdata[3:0] == `CBT_CONN_CODE) begin
         for (int i = 0; i < 7; i++) begin
            stb[i] = pwdata[15-i] & ~out6_q[15-i];
         end
      end
   end
   // bus answer: ready one cycle into the access phase
   always_comb begin
      out5_d = out5_q;
      out6_d = out6_q;
      pready_d = psel & penable & ~pready;
      prdata_d = prdata;
      pslverr_d = 1'b0;
      if (psel && penable && !pready) begin
         prdata_d = `CBT_Z32;
         unique case (paddr[7:0])
            `CBT_A_OUT5: prdata_d = {16'h0, out5_q};
            `CBT_A_OUT6: prdata_d = {16'h0, out6_q};
            `CBT_A_STAT5: prdata_d = conn ? {16'h0, stat5} : `CBT_Z32;
            `CBT_A_STAT6: prdata_d = conn ? {20'h0, dat_s[11:0]} : `CBT_Z32;
            default: pslverr_d = 1'b1;
         endcase
         if (paddr[AW-1:0] > AW'(`CBT_A_STAT6)) begin
            pslverr_d = 1'b1;
         end
      end
      if (take && pwrite && paddr[7:0] == `CBT_A_OUT5) begin
         out5_d = pwdata[15:0];
      end
      if (wr6) begin
         out6_d = pwdata[15:0];
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         out5_q <= `CBT_Z16;
         out6_q <= `CBT_Z16;
         pready <= 1'b0;
         prdata <= `CBT_Z32;
         pslverr <= 1'b0;
      end else if (ce) begin
         out5_q <= out5_d;
         out6_q <= out6_d;
         pready <= pready_d;
         prdata <= prdata_d;
         pslverr <= pslverr_d;
      end
   end

   // ******************************************************
   // transfer engine
   // ******************************************************
   cbt_state_type st_q, st_d;
   logic [10:0] low_d;
   logic [3:0] page_d;
   logic [14:0] term_q, term_d;
   logic cmp_q, cmp_d;
   logic [6:0] tbl_q, tbl_d;
   logic [15:0] fn_q, fn_d, word_q, word_d;
   logic [11:0] byte_q, byte_d;
   logic [1:0] ucnt_d, bcnt_d;
   logic last_q, last_d, sbu_perr_d, rd_perr_d;
   logic fresh_q, fresh_d;
   logic mreq_d, mwe_d;
   logic [14:0] maddr_d;
   logic [15:0] mwdata_d;
   logic txv_d, cstb_d, cconn_d;
   logic [11:0] txb_d, code_d;
   logic coded, wrt, dis, halt, back, adv, hit, wfull, bfull;
   logic [10:0] nlow;
   logic [3:0] npage;
   assign coded = fn_q[`CBT_F_CODED];
   assign wrt = fn_q[`CBT_F_WRITE];
   assign dis = fn_q[`CBT_F_DISREQ];
   assign halt = fn_q[`CBT_F_HALT];
   assign back = fn_q[`CBT_F_BACK];
   // compare only ever consulted on write fetches
   assign hit = cmp_q & (term_q[14:11] == page_q) & (term_q[10:0] == low_q);
   // address step: low part only, page taken from terminating word at end
   always_comb begin
      nlow = back ? low_q - 11'h1 : low_q + 11'h1;
      npage = page_q;
      if (!back && low_q == `CBT_PAGE_END) begin
         nlow = `CBT_PAGE_TOP;
         npage = term_q[14:11];
      end
   end
   // sequencing of units between peripheral bytes, tables and memory words
   always_comb begin
      st_d = st_q;
      low_d = low_q;
      page_d = page_q;
      term_d = term_q;
      cmp_d = cmp_q;
      tbl_d = tbl_q;
      fn_d = fn_q;
      word_d = word_q;
      byte_d = byte_q;
      ucnt_d = ucnt_q;
      bcnt_d = bcnt_q;
      last_d = last_q;
      fresh_d = 1'b0;
      sbu_perr_d = sbu_perr_q;
      rd_perr_d = rd_perr_q;
      mreq_d = mem_req;
      mwe_d = mem_we;
      maddr_d = mem_addr;
      mwdata_d = mem_wdata;
      txv_d = per_tx_valid;
      txb_d = per_tx_byte;
      cstb_d = 1'b0;
      cconn_d = per_code_conn;
      code_d = per_code;
      adv = 1'b0;
      wfull = 1'b0;
      bfull = 1'b0;
      unique case (st_q)
         ST_RXW: begin
            if (rx_new) begin
               byte_d = dat_s[23:12];
               bcnt_d = coded ? 2'd2 : 2'd3;
               if (ctl_s[2]) begin
                  rd_perr_d = 1'b1;
               end
               st_d = (ctl_s[2] && halt) ? ST_IDLE : ST_UNIT;
            end
         end
         ST_UNIT: begin
            if (!wrt && bcnt_q == 2'd0) begin
               st_d = ST_RXW;
            end else if (wrt && ucnt_q == 2'd0 && !fresh_q) begin
               st_d = last_q ? ST_IDLE : ST_FETCH;
               mreq_d = ~last_q & ~dis;
               mwe_d = 1'b0;
               maddr_d = {page_q, low_q};
            end else if (!wrt && !coded) begin
               word_d = {word_q[11:0], byte_q[11:8]};
               byte_d = {byte_q[7:0], 4'h0};
               bcnt_d = bcnt_q - 2'd1;
               ucnt_d = ucnt_q + 2'd1;
               wfull = ucnt_q == 2'd3;
            end else if (!wrt) begin
               maddr_d = {tbl_q, 2'b00, byte_q[11:6]};
               byte_d = {byte_q[5:0], 6'h0};
               bcnt_d = bcnt_q - 2'd1;
               mreq_d = 1'b1;
               mwe_d = 1'b0;
               st_d = ST_LOOK;
            end else if (!coded) begin
               byte_d = {byte_q[7:0], word_q[15:12]};
               word_d = {word_q[11:0], 4'h0};
               ucnt_d = ucnt_q - 2'd1;
               bcnt_d = bcnt_q + 2'd1;
               bfull = bcnt_q == 2'd2;
            end else begin
               maddr_d = {tbl_q, word_q[15:8]};
               word_d = {word_q[7:0], 8'h0};
               ucnt_d = ucnt_q - 2'd1;
               mreq_d = 1'b1;
               mwe_d = 1'b0;
               st_d = ST_LOOK;
            end
         end
         ST_LOOK: begin
            if (mem_ack) begin
               mreq_d = 1'b0;
               st_d = ST_UNIT;
               if (wrt) begin
                  byte_d = {byte_q[5:0], mem_rdata[5:0]};
                  bcnt_d = bcnt_q + 2'd1;
                  bfull = bcnt_q == 2'd1;
               end else begin
                  word_d = {word_q[7:0], mem_rdata[7:0]};
                  ucnt_d = ucnt_q + 2'd1;
                  wfull = ucnt_q == 2'd1;
               end
            end
         end
         ST_STORE: begin
            if (mem_ack || dis) begin
               mreq_d = 1'b0;
               adv = 1'b1;
               ucnt_d = 2'd0;
               st_d = ST_UNIT;
            end
         end
         ST_FETCH: begin
            if (mem_ack || dis) begin
               mreq_d = 1'b0;
               word_d = dis ? `CBT_Z16 : mem_rdata;
               ucnt_d = coded ? 2'd2 : 2'd0;
               last_d = hit;
               adv = 1'b1;
               st_d = ST_UNIT;
               if (mem_ack && mem_perr) begin
                  sbu_perr_d = 1'b1;
                  st_d = halt ? ST_IDLE : ST_UNIT;
               end
            end
         end
         ST_SEND: begin
            if (txack_new) begin
               txv_d = 1'b0;
               bcnt_d = 2'd0;
               st_d = ST_UNIT;
               if (ctl_s[1]) begin
                  rd_perr_d = 1'b1;
               end
               if (ctl_s[1] && halt) begin
                  st_d = ST_IDLE;
               end
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      // binary fetch yields four nibbles; counter wraps to mean four
      if (st_q == ST_FETCH && st_d == ST_UNIT && !coded) begin
         ucnt_d = 2'd0;
         last_d = hit;
         fresh_d = 1'b1; // a zero count here means a full word, not an empty one
      end
      if (wfull) begin
         st_d = ST_STORE;
         mreq_d = ~dis;
         mwe_d = 1'b1;
         maddr_d = {page_q, low_q};
         mwdata_d = word_d;
      end
      if (bfull) begin
         st_d = ST_SEND;
         txv_d = 1'b1;
         txb_d = byte_d;
      end
      if (adv) begin
         low_d = nlow;
         page_d = npage;
      end
      // end of record finishes reads only; compare never does
      if (!wrt && st_q != ST_IDLE && eor_new) begin
         st_d = ST_IDLE;
      end
      if (st_d == ST_IDLE) begin
         mreq_d = 1'b0;
         txv_d = 1'b0;
      end
      // strobed host words, all addresses arrive complemented
      if (stb[`CBT_S_SA]) begin
         page_d = ~out5_q[14:11];
         low_d = ~out5_q[10:0];
      end
      if (stb[`CBT_S_TA]) begin
         term_d = ~out5_q[14:0];
         cmp_d = out5_q[`CBT_CMP_BIT];
      end
      if (stb[`CBT_S_TB]) begin
         tbl_d = ~out5_q[14:8];
      end
      if (stb[`CBT_S_CC]) begin
         code_d = out5_q[11:0];
         cconn_d = out5_q[`CBT_CCONN_BIT];
         cstb_d = 1'b1;
      end
      if (stb[`CBT_S_FN]) begin
         fn_d = out5_q;
         st_d = out5_q[`CBT_F_WRITE] ? ST_FETCH : ST_RXW;
         ucnt_d = 2'd0;
         bcnt_d = 2'd0;
         last_d = 1'b0;
         mreq_d = out5_q[`CBT_F_WRITE] & ~out5_q[`CBT_F_DISREQ];
         mwe_d = 1'b0;
         maddr_d = {page_d, low_d};
      end
      if (stb[`CBT_S_CLR]) begin
         st_d = ST_IDLE;
         fn_d = `CBT_Z16;
         mreq_d = 1'b0;
         txv_d = 1'b0;
         // an error seen in this very cycle still wins over the clear
         sbu_perr_d = (st_q == ST_FETCH) & mem_ack & mem_perr;
         rd_perr_d = (st_q == ST_RXW & rx_new & ctl_s[2]) | (st_q == ST_SEND & txack_new & ctl_s[1]);
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         low_q <= `CBT_PAGE_TOP;
         page_q <= 4'h0;
         term_q <= 15'h0000;
         cmp_q <= 1'b0;
         tbl_q <= 7'h00;
         fn_q <= `CBT_Z16;
         word_q <= `CBT_Z16;
         byte_q <= 12'h000;
         ucnt_q <= 2'd0;
         bcnt_q <= 2'd0;
         last_q <= 1'b0;
         fresh_q <= 1'b0;
         sbu_perr_q <= 1'b0;
         rd_perr_q <= 1'b0;
         ctl_p_q <= 5'h00;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 15'h0000;
         mem_wdata <= `CBT_Z16;
         per_tx_valid <= 1'b0;
         per_tx_byte <= 12'h000;
         per_code_stb <= 1'b0;
         per_code_conn <= 1'b0;
         per_code <= 12'h000;
         eng_state <= ST_IDLE;
      end else if (ce) begin
         st_q <= st_d;
         low_q <= low_d;
         page_q <= page_d;
         term_q <= term_d;
         cmp_q <= cmp_d;
         tbl_q <= tbl_d;
         fn_q <= fn_d;
         word_q <= word_d;
         byte_q <= byte_d;
         ucnt_q <= ucnt_d;
         bcnt_q <= bcnt_d;
         last_q <= last_d;
         fresh_q <= fresh_d;
         sbu_perr_q <= sbu_perr_d;
         rd_perr_q <= rd_perr_d;
         ctl_p_q <= ctl_s;
         mem_req <= mreq_d;
         mem_we <= mwe_d;
         mem_addr <= maddr_d;
         mem_wdata <= mwdata_d;
         per_tx_valid <= txv_d;
         per_tx_byte <= txb_d;
         per_code_stb <= cstb_d;
         per_code_conn <= cconn_d;
         per_code <= code_d;
         eng_state <= st_d;
      end
   end

   // ******************************************************
   // checks
   // ******************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst || !ce);
   sequence s_fn_write;
      stb[`CBT_S_FN] && out5_q[`CBT_F_WRITE] && !out5_q[`CBT_F_DISREQ];
   endsequence
   property p_start_write;
      s_fn_write |=> st_q == ST_FETCH && mem_req && !mem_we;
   endproperty
   a_start_write: assert property (p_start_write) else $error("write did not start");
   property p_clear;
      stb[`CBT_S_CLR] |=> st_q == ST_IDLE && fn_q == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left state");
   property p_rd_look;
      st_q == ST_LOOK && !wrt |-> mem_addr[7:6] == 2'b00 && mem_addr[14:8] == tbl_q;
   endproperty
   a_rd_look: assert property (p_rd_look) else $error("bad read table address");
   property p_wr_look;
      $past(st_q) == ST_UNIT && st_q == ST_LOOK && wrt
         |-> mem_addr[14:8] == tbl_q && mem_addr[7:0] == $past(word_q[15:8]);
   endproperty
   a_wr_look: assert property (p_wr_look) else $error("bad write table address");
   property p_incr;
      st_q == ST_STORE && mem_ack && !back && low_q != 11'h7ff
         |=> low_q == $past(low_q) + 11'h1 && $stable(page_q);
   endproperty
   a_incr: assert property (p_incr) else $error("address step wrong");
   property p_page;
      (st_q == ST_STORE || st_q == ST_FETCH) && mem_ack && !back && low_q == 11'h7ff
         && !stb[`CBT_S_SA] |=> low_q == 11'h000 && page_q == $past(term_q[14:11]);
   endproperty
   a_page: assert property (p_page) else $error("page chain wrong");
   property p_eor;
      !wrt && st_q != ST_IDLE && eor_new && !stb[`CBT_S_FN] |=> st_q == ST_IDLE;
   endproperty
   a_eor: assert property (p_eor) else $error("end of record ignored");
   property p_perr;
      st_q == ST_FETCH && mem_ack && mem_perr && !halt && stb == 7'h00
         |=> st_q == ST_UNIT ##0 sbu_perr_q;
   endproperty
   a_perr: assert property (p_perr) else $error("parity stopped without halt");
   property p_idle;
      st_q == ST_IDLE |-> !mem_req && !per_tx_valid;
   endproperty
   a_idle: assert property (p_idle) else $error("idle still active");
   property p_stat;
      pready && !pwrite && paddr[7:0] == `CBT_A_STAT5 && !$past(conn) |-> prdata == 32'h0;
   endproperty
   a_stat: assert property (p_stat) else $error("status without connect");
endmodule

/* tb/cbt_far_model.sv */
// behavioural buffer memory and output side of a tape controller
`timescale 1ns/1ps
module cbt_far_model (
   input wire logic clk_sys,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [14:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   output logic mem_perr,
   input wire logic perr_en,
   input wire logic [14:0] perr_addr,
   input wire logic per_tx_valid,
   input wire logic [11:0] per_tx_byte,
   output logic per_tx_ack
);
   logic [15:0] mem [0:32767];
   logic [11:0] tx_q [$];
   // memory answers after zero to three extra cycles; data scrambles between answers
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
      mem_perr = 1'b0;
      forever begin
         @(posedge clk_sys);
         if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
            repeat (mem_addr[1:0]) @(posedge clk_sys);
            if (mem_we === 1'b1) mem[mem_addr] = mem_wdata;
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr];
            mem_perr <= perr_en && mem_we === 1'b0 && mem_addr === perr_addr;
         end else begin
            mem_ack <= 1'b0;
            mem_perr <= 1'b0;
            mem_rdata <= ~mem_rdata;
         end
      end
   end
   // controller takes each byte, acknowledges with a level held until valid drops
   initial begin
      per_tx_ack = 1'b0;
      forever begin
         @(posedge clk_sys);
         if (per_tx_valid === 1'b1) begin
            repeat (2) @(posedge clk_sys);
            tx_q.push_back(per_tx_byte);
            per_tx_ack <= 1'b1;
            while (per_tx_valid === 1'b1) @(posedge clk_sys);
            per_tx_ack <= 1'b0;
         end
      end
   end
endmodule

/* tb/tb_cbt_top.sv */
// self-checking bench of the block transfer channel
`timescale 1ns/1ps
`include "cbt_regs.svh"
module tb_cbt_top;
   import cbt_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, x, seed = 32'd31057;
   logic pready, pslverr, err, mem_req, mem_we, mem_ack, mem_perr, per_tx_valid, per_tx_ack;
   logic per_rx_valid = 1'b0, per_eor = 1'b0, perr_en = 1'b0, per_code_stb, per_code_conn;
   logic [14:0] mem_addr;
   logic [15:0] mem_wdata, mem_rdata;
   logic [11:0] per_rx_byte = 12'h000, per_status = 12'h000, per_tx_byte, per_code;
   logic [12:0] code_seen;
   logic [95:0] s;
   cbt_state_type eng_state;
   int miscompares = 0, n_compared = 0, n_stb = 0;
   cbt_top #(.AW(8)) dut (.clk_sys, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
      .mem_rdata, .mem_perr, .per_rx_valid, .per_rx_byte, .per_eor, .per_rx_perr(1'b0),
      .per_wr_perr(1'b0), .per_tx_ack, .per_status, .per_tx_valid, .per_tx_byte, .per_code_stb,
      .per_code_conn, .per_code, .eng_state);
   cbt_far_model far (.clk_sys, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
      .mem_perr, .perr_en, .perr_addr(15'h0101), .per_tx_valid, .per_tx_byte, .per_tx_ack);
   // ****************
   // helpers
   // ****************
   initial forever #25 clk_sys = ~clk_sys;
   // capture of every code pulse sent to the controllers
   always @(posedge clk_sys) if (per_code_stb === 1'b1) begin
      code_seen <= {per_code_conn, per_code};
      n_stb <= n_stb + 1;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", pready, 1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   // word on the output path, then set and clear its class strobe while connected
   task automatic strobe(input int b, input logic [15:0] v);
      apb(1'b1, `CBT_A_OUT5, {16'h0000, v});
      apb(1'b1, `CBT_A_OUT6, {16'h0000, 16'h8000 >> b} | 32'h0000_000c);
      apb(1'b1, `CBT_A_OUT6, 32'h0000_000c);
   endtask
   task automatic wait_idle(input int lim);
      int n;
      n = 0;
      while (eng_state !== ST_IDLE && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      chk("engine idle", eng_state, ST_IDLE);
   endtask
   // controller byte: data settles before the edge, scrambled once released
   task automatic rx(input logic [11:0] b);
      per_rx_byte <= b;
      repeat (4) @(posedge clk_sys);
      per_rx_valid <= 1'b1;
      repeat (4) @(posedge clk_sys);
      per_rx_valid <= 1'b0;
      per_rx_byte <= ~b;
      repeat (30) @(posedge clk_sys);
   endtask
   task automatic end_record();
      per_eor <= 1'b1;
      repeat (6) @(posedge clk_sys);
      per_eor <= 1'b0;
      wait_idle(20);
   endtask
   // ****************
   // scenarios
   // ****************
   initial begin
      #1_000_000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      chk("outputs in reset", {mem_req, per_tx_valid, per_code_stb, pready}, 0);
      rst <= 1'b0;
      x = rnd();
      per_status <= x[11:0];
      apb(1'b0, `CBT_A_STAT6, 32'h0);
      chk("status unconnected", rd, 0);
      apb(1'b0, `CBT_A_STAT5, 32'h0);
      chk("status5 unconnected", rd, 0);
      apb(1'b1, `CBT_A_OUT6, 32'h0000_000c);
      apb(1'b0, `CBT_A_STAT6, 32'h0);
      chk("controller status", rd, {20'h00000, x[11:0]});
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", err, 1);
      for (int i = 0; i < 2; i++) begin
         x = rnd();
         strobe(`CBT_S_CC, {2'b00, i[0], 1'b0, x[11:0]});
         chk("controller code", code_seen, {i[0], x[11:0]});
      end
      apb(1'b1, `CBT_A_OUT6, 32'h0000_0800);
      apb(1'b1, `CBT_A_OUT6, 32'h0000_0000);
      chk("code pulses", n_stb, 2);
      // write binary across a page end into a chained page
      for (int i = 0; i < 3; i++) begin
         x = rnd();
         s[95-16*i -: 16] = x[15:0];
         far.mem[i < 2 ? 15'h0ffe + i : 15'h1800] = x[15:0];
      end
      strobe(`CBT_S_SA, {1'b0, ~15'h0ffe});
      strobe(`CBT_S_TA, {1'b1, ~15'h1800});
      strobe(`CBT_S_FN, 16'h4000);
      wait_idle(2000);
      chk("bytes sent", far.tx_q.size(), 4);
      for (int i = 0; i < 4; i++) chk("sent byte", far.tx_q[i], s[95-12*i -: 12]);
      // read binary, compare hit must not end it, page chained
      strobe(`CBT_S_SA, {1'b0, ~15'h27fe});
      strobe(`CBT_S_TA, {1'b1, ~15'h3000});
      strobe(`CBT_S_FN, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         x = rnd();
         s[95-12*i -: 12] = x[11:0];
         rx(x[11:0]);
      end
      chk("still reading", eng_state === ST_IDLE, 0);
      end_record();
      for (int i = 0; i < 6; i++)
         chk("stored word", far.mem[i < 2 ? 15'h27fe + i : 15'h2ffe + i], s[95-16*i -: 16]);
      // current address status after six words across the page change
      apb(1'b1, `CBT_A_OUT6, 32'h0000_020c);
      apb(1'b0, `CBT_A_STAT5, 32'h0);
      chk("current address", rd, 32'h0000_0004);
      // read coded through a table in quarter page 15
      for (int i = 0; i < 64; i++) begin
         x = rnd();
         far.mem[15'h1500 + i] = {x[7:0], x[7:0]};
      end
      strobe(`CBT_S_TB, {1'b0, ~7'h15, 8'h00});
      strobe(`CBT_S_SA, {1'b0, ~15'h0400});
      strobe(`CBT_S_FN, 16'h8000);
      for (int i = 0; i < 2; i++) begin
         x = rnd();
         rx(x[11:0]);
         s[15:0] = {far.mem[15'h1500 + x[11:6]][7:0], far.mem[15'h1500 + x[5:0]][7:0]};
         chk("coded word", far.mem[15'h0400 + i], s[15:0]);
      end
      end_record();
      // write coded through a table in quarter page 22, two words give two bytes
      for (int i = 0; i < 256; i++) begin
         x = rnd();
         far.mem[15'h2200 + i] = {2'b00, x[5:0], 2'b00, x[5:0]};
      end
      x = rnd();
      far.mem[15'h0500] = x[31:16];
      far.mem[15'h0501] = x[15:0];
      far.tx_q.delete();
      strobe(`CBT_S_TB, {1'b0, ~7'h22, 8'h00});
      strobe(`CBT_S_SA, {1'b0, ~15'h0500});
      strobe(`CBT_S_TA, {1'b1, ~15'h0501});
      strobe(`CBT_S_FN, 16'hc000);
      wait_idle(2000);
      chk("coded bytes", far.tx_q.size(), 2);
      for (int i = 0; i < 2; i++) begin
         s[11:6] = far.mem[15'h2200 + x[31-16*i -: 8]][5:0];
         s[5:0] = far.mem[15'h2200 + x[23-16*i -: 8]][5:0];
         chk("coded byte", far.tx_q[i], s[11:0]);
      end
      // memory parity on a fetch: ignored, then halting
      perr_en <= 1'b1;
      for (int h = 0; h < 2; h++) begin
         far.tx_q.delete();
         strobe(`CBT_S_CLR, 16'h0000);
         strobe(`CBT_S_SA, {1'b0, ~15'h0100});
         strobe(`CBT_S_TA, {1'b1, ~15'h0103});
         strobe(`CBT_S_FN, 16'h4000 | (16'h0400 * h[0]));
         wait_idle(2000);
         chk("full length", far.tx_q.size() == 5, !h[0]);
         apb(1'b0, `CBT_A_STAT5, 32'h0);
         chk("memory parity flag", rd[12], 1);
      end
      perr_en <= 1'b0;
      // master clear in mid transfer
      strobe(`CBT_S_SA, {1'b0, ~15'h0200});
      strobe(`CBT_S_TA, {1'b0, ~15'h0000});
      strobe(`CBT_S_FN, 16'h4000);
      repeat (40) @(posedge clk_sys);
      strobe(`CBT_S_CLR, 16'h0000);
      wait_idle(10);
      repeat (30) @(posedge clk_sys);
      chk("stays idle", eng_state, ST_IDLE);
      apb(1'b0, `CBT_A_STAT5, 32'h0);
      chk("flag cleared", rd[12], 0);
      report_and_stop();
   end
endmodule
